// ---- logic/dte_pkg.sv ----
package dte_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the control bus
  localparam logic [7:0] OFF_GPR0 = 8'h00;
  localparam logic [7:0] OFF_DSEG = 8'h20;
  localparam logic [7:0] OFF_XSEG = 8'h24;
  localparam logic [7:0] OFF_FLAGS = 8'h28;
  localparam logic [7:0] OFF_EA = 8'h2c;
  localparam logic [7:0] OFF_IMM = 8'h30;
  localparam logic [7:0] OFF_CMD = 8'h34;
  localparam logic [7:0] OFF_STAT = 8'h38;
  ////////////////////////////////////////////////////////////////////////////
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WORD = 4;
  localparam int CMD_DST_LSB = 5;
  localparam int CMD_SRC_LSB = 8;
  localparam int CMD_MEM = 11;
  localparam int CMD_MDST = 12;
  localparam int CMD_IMM = 13;
  localparam int CMD_LOCK = 14;
  ////////////////////////////////////////////////////////////////////////////
  // flag word layout
  localparam logic [15:0] FL_DEFINED = 16'h0fd5;
  localparam logic [15:0] FL_LOW_MASK = 16'h00d5;
  localparam logic [15:0] FL_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // register indices and byte selects
  localparam logic [2:0] R_ACC = 3'h0;
  localparam logic [2:0] R_PORT = 3'h2;
  localparam logic [2:0] R_BASE = 3'h3;
  localparam logic [2:0] R_STK = 3'h4;
  localparam logic [2:0] SEL_ACC_LO = 3'h0;
  localparam logic [2:0] SEL_ACC_HI = 3'h4;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] PTR_SEG_OFS = 16'h0002;
  localparam int MEM_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  // operation codes and sequencer states
  typedef enum logic [3:0] {
    OP_MOVE = 4'h0, OP_PUSH = 4'h1, OP_POP = 4'h2, OP_SWAP = 4'h3,
    OP_LOOKUP = 4'h4, OP_IN = 4'h5, OP_OUT = 4'h6, OP_OFSLOAD = 4'h7,
    OP_PTRDSEG = 4'h8, OP_PTRXSEG = 4'h9, OP_FLTOHI = 4'ha, OP_HITOFL = 4'hb,
    OP_FLPUSH = 4'hc, OP_FLPOP = 4'hd
  } dte_op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_DEC, S_RD, S_RDW, S_WR, S_WB, S_IO
  } dte_state_t;
endpackage : dte_pkg

// ---- logic/dte_mem.sv ----
module dte_mem (
  input wire logic mclk_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [1:0] be_in,
  input wire logic [dte_pkg::MEM_AW-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem_q [0:(1<<dte_pkg::MEM_AW)-1];

  // byte-lane writes
  always_ff @(posedge mclk_in) begin
    if (en_in && we_in) begin
      if (be_in[0]) mem_q[addr_in][7:0] <= wdata_in[7:0];
      if (be_in[1]) mem_q[addr_in][15:8] <= wdata_in[15:8];
    end
  end

  // registered read port
  always_ff @(posedge mclk_in) begin
    if (en_in && !we_in) rdata_out <= mem_q[addr_in];
  end
endmodule : dte_mem

// ---- logic/dte_core.sv ----
// Contract
// RQ1 - move copies source to destination, source kept
// RQ2 - push lowers stack pointer two, then writes
// RQ3 - pop reads top, then raises pointer two
// RQ4 - swap exchanges operands; locked swap indivisible
// RQ5 - table lookup replaces low accumulator byte
// RQ6 - port input loads byte or word
// RQ7 - port output sends byte or word
// RQ8 - offset load writes address, flags unchanged
// RQ9 - data pointer load: offset and data segment
// RQ10 - extra pointer load: offset and extra segment
// RQ11 - flags copied into high accumulator byte
// RQ12 - high accumulator byte loads five low flags
// RQ13 - flags push lowers pointer, stores flag word
// RQ14 - flags pop loads defined bits, raises pointer
// RQ15 - trap flag image at stacked bit eight
// RQ16 - stack pointer wraps modulo 65536
module dte_core (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic io_req_out,
  output logic io_wr_out,
  output logic io_word_out,
  output logic [15:0] io_addr_out,
  output logic [15:0] io_wdata_out,
  input wire logic [15:0] io_rdata_in,
  input wire logic io_ack_in,
  output logic bus_lock_out,
  output logic busy_out
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  dte_pkg::dte_state_t state_q, state_d;
  dte_pkg::dte_op_t op;
  logic [15:0] gpr [0:7];
  logic [15:0] dseg_q, xseg_q, flags_q, ea_q, imm_q, cmd_q;
  logic [15:0] addr_q, addr_d, tmp_q, tmp_d, stk_ptr, src_val, mem_val, mem_rdata;
  logic phase_q, phase_d, bad_op_q, start, w, op_word;
  logic [2:0] dsel, ssel;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q, axi_wr, sw_we;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_mux;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rf_we, rf_word, stk_we, dseg_we, xseg_we, fl_we;
  logic [2:0] rf_sel;
  logic [15:0] rf_data, stk_data, seg_data, fl_mask, fl_data;
  logic [15:0] sw_val, src_reg, dst_reg, dst_val;
  logic [2:0] rf_widx;
  logic rf_hi;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= dte_pkg::OFF_STAT);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  assign op = dte_pkg::dte_op_t'(cmd_q[dte_pkg::CMD_OP_LSB +: 4]);
  assign w = cmd_q[dte_pkg::CMD_WORD];
  assign dsel = cmd_q[dte_pkg::CMD_DST_LSB +: 3];
  assign ssel = cmd_q[dte_pkg::CMD_SRC_LSB +: 3];
  assign stk_ptr = gpr[dte_pkg::R_STK];
  assign op_word = w || !(op inside {dte_pkg::OP_MOVE, dte_pkg::OP_SWAP, dte_pkg::OP_LOOKUP});
  // byte operand reads: selects 0-3 low halves, 4-7 high halves of regs 0-3
  assign src_reg = gpr[op_word ? ssel : {1'b0, ssel[1:0]}];
  assign dst_reg = gpr[w ? dsel : {1'b0, dsel[1:0]}];
  assign src_val = cmd_q[dte_pkg::CMD_IMM] ? imm_q
                 : op_word ? src_reg : {8'h00, ssel[2] ? src_reg[15:8] : src_reg[7:0]};
  assign dst_val = w ? dst_reg : {8'h00, dsel[2] ? dst_reg[15:8] : dst_reg[7:0]};
  assign mem_val = op_word ? mem_rdata
                 : {8'h00, addr_q[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
  assign busy_out = (state_q != dte_pkg::S_IDLE);
  assign bus_lock_out = busy_out && cmd_q[dte_pkg::CMD_LOCK]; // RQ4
  assign io_req_out = (state_q == dte_pkg::S_IO);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: write path
  assign s_axi_awready_out = !aw_full_q;
  assign s_axi_wready_out = !w_full_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign axi_wr = aw_full_q && w_full_q && !bvalid_q;
  assign sw_we = axi_wr && mapped(awaddr_q) && !busy_out;
  assign start = sw_we && (awaddr_q == dte_pkg::OFF_CMD);
  assign sw_val = wdata_q[15:0];

  // address and data capture, either order
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end else if (axi_wr) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid_in && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end else if (axi_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= dte_pkg::RESP_OKAY;
    end else if (axi_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(awaddr_q) ? dte_pkg::RESP_OKAY : dte_pkg::RESP_DECERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: read path, one cycle latency
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr_in < dte_pkg::OFF_DSEG) rd_mux[15:0] = gpr[s_axi_araddr_in[4:2]];
    case (s_axi_araddr_in)
      dte_pkg::OFF_DSEG: rd_mux[15:0] = dseg_q;
      dte_pkg::OFF_XSEG: rd_mux[15:0] = xseg_q;
      dte_pkg::OFF_FLAGS: rd_mux[15:0] = flags_q;
      dte_pkg::OFF_EA: rd_mux[15:0] = ea_q;
      dte_pkg::OFF_IMM: rd_mux[15:0] = imm_q;
      dte_pkg::OFF_CMD: rd_mux[15:0] = cmd_q;
      dte_pkg::OFF_STAT: rd_mux[2:0] = {bad_op_q, bus_lock_out, busy_out};
      default: ;
    endcase
  end

  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // read data register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dte_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= mapped(s_axi_araddr_in) ? rd_mux : 32'h0000_0000;
      rresp_q <= mapped(s_axi_araddr_in) ? dte_pkg::RESP_OKAY : dte_pkg::RESP_DECERR;
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general registers; execution write beats stack adjust beats software
  assign rf_widx = rf_word ? rf_sel : {1'b0, rf_sel[1:0]};
  assign rf_hi = !rf_word && rf_sel[2];
  for (genvar i = 0; i < 8; i++) begin : g_gpr
    logic [15:0] q;
    assign gpr[i] = q;
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        q <= dte_pkg::REG_RESET;
      end else if (rf_we && rf_widx == 3'(i)) begin
        if (rf_word) q <= rf_data;
        else if (rf_hi) q[15:8] <= rf_data[7:0];
        else q[7:0] <= rf_data[7:0];
      end else if (stk_we && dte_pkg::R_STK == 3'(i)) begin
        q <= stk_data; // RQ16
      end else if (sw_we && awaddr_q < dte_pkg::OFF_DSEG && awaddr_q[4:2] == 3'(i)) begin
        if (wstrb_q[0]) q[7:0] <= sw_val[7:0];
        if (wstrb_q[1]) q[15:8] <= sw_val[15:8];
      end
    end
  end

  // segment, flag and command registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dseg_q <= dte_pkg::REG_RESET;
      xseg_q <= dte_pkg::REG_RESET;
      flags_q <= dte_pkg::FL_RESET;
      ea_q <= dte_pkg::REG_RESET;
      imm_q <= dte_pkg::REG_RESET;
      cmd_q <= dte_pkg::REG_RESET;
    end else if (busy_out) begin
      if (dseg_we) dseg_q <= seg_data; // RQ9
      if (xseg_we) xseg_q <= seg_data; // RQ10
      if (fl_we) flags_q <= (flags_q & ~fl_mask) | (fl_data & fl_mask);
    end else if (sw_we) begin
      case (awaddr_q)
        dte_pkg::OFF_DSEG: dseg_q <= sw_val;
        dte_pkg::OFF_XSEG: xseg_q <= sw_val;
        dte_pkg::OFF_FLAGS: flags_q <= sw_val & dte_pkg::FL_DEFINED;
        dte_pkg::OFF_EA: ea_q <= sw_val;
        dte_pkg::OFF_IMM: imm_q <= sw_val;
        dte_pkg::OFF_CMD: cmd_q <= sw_val;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution sequencer: next state and write ports
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    tmp_d = tmp_q;
    phase_d = phase_q;
    rf_we = 1'b0;
    rf_sel = dsel;
    rf_word = op_word;
    rf_data = mem_val;
    stk_we = 1'b0;
    stk_data = stk_ptr - dte_pkg::STACK_STEP; // RQ16
    dseg_we = 1'b0;
    xseg_we = 1'b0;
    seg_data = mem_rdata;
    fl_we = 1'b0;
    fl_mask = dte_pkg::FL_DEFINED;
    fl_data = mem_rdata;
    case (state_q)
      dte_pkg::S_IDLE: begin
        phase_d = 1'b0;
        if (start) state_d = dte_pkg::S_DEC;
      end
      dte_pkg::S_DEC: begin
        state_d = dte_pkg::S_IDLE;
        case (op)
          dte_pkg::OP_MOVE: begin
            addr_d = ea_q;
            tmp_d = src_val;
            if (cmd_q[dte_pkg::CMD_MEM]) begin
              state_d = cmd_q[dte_pkg::CMD_MDST] ? dte_pkg::S_WR : dte_pkg::S_RD;
            end else begin
              rf_we = 1'b1; // RQ1
              rf_data = src_val;
            end
          end
          dte_pkg::OP_PUSH, dte_pkg::OP_FLPUSH: begin
            stk_we = 1'b1; // RQ2 RQ13
            addr_d = stk_data;
            tmp_d = (op == dte_pkg::OP_PUSH) ? src_val : (flags_q & dte_pkg::FL_DEFINED); // RQ15
            state_d = dte_pkg::S_WR;
          end
          dte_pkg::OP_POP, dte_pkg::OP_FLPOP: begin
            addr_d = stk_ptr;
            state_d = dte_pkg::S_RD;
          end
          dte_pkg::OP_SWAP: begin
            tmp_d = dst_val;
            addr_d = ea_q;
            if (cmd_q[dte_pkg::CMD_MEM]) begin
              state_d = dte_pkg::S_RD;
            end else begin
              rf_we = 1'b1; // RQ4
              rf_data = src_val;
              state_d = dte_pkg::S_WB;
            end
          end
          dte_pkg::OP_LOOKUP: begin
            addr_d = gpr[dte_pkg::R_BASE] + {8'h00, gpr[dte_pkg::R_ACC][7:0]}; // RQ5
            state_d = dte_pkg::S_RD;
          end
          dte_pkg::OP_IN, dte_pkg::OP_OUT: state_d = dte_pkg::S_IO;
          dte_pkg::OP_OFSLOAD: begin
            rf_we = 1'b1; // RQ8
            rf_data = ea_q;
          end
          dte_pkg::OP_PTRDSEG, dte_pkg::OP_PTRXSEG: begin
            addr_d = ea_q;
            state_d = dte_pkg::S_RD;
          end
          dte_pkg::OP_FLTOHI: begin
            rf_we = 1'b1; // RQ11
            rf_word = 1'b0;
            rf_sel = dte_pkg::SEL_ACC_HI;
            rf_data = flags_q & dte_pkg::FL_LOW_MASK;
          end
          dte_pkg::OP_HITOFL: begin
            fl_we = 1'b1; // RQ12
            fl_mask = dte_pkg::FL_LOW_MASK;
            fl_data = {8'h00, gpr[dte_pkg::R_ACC][15:8]};
          end
          default: ;
        endcase
      end
      dte_pkg::S_RD: state_d = dte_pkg::S_RDW;
      dte_pkg::S_RDW: begin
        state_d = dte_pkg::S_IDLE;
        case (op)
          dte_pkg::OP_MOVE: rf_we = 1'b1; // RQ1
          dte_pkg::OP_POP: begin
            rf_we = 1'b1; // RQ3
            stk_we = 1'b1;
            stk_data = stk_ptr + dte_pkg::STACK_STEP;
          end
          dte_pkg::OP_SWAP: begin
            rf_we = 1'b1; // RQ4
            state_d = dte_pkg::S_WR;
          end
          dte_pkg::OP_LOOKUP: begin
            rf_we = 1'b1; // RQ5
            rf_word = 1'b0;
            rf_sel = dte_pkg::SEL_ACC_LO;
          end
          dte_pkg::OP_PTRDSEG, dte_pkg::OP_PTRXSEG: begin
            if (!phase_q) begin
              rf_we = 1'b1;
              phase_d = 1'b1;
              addr_d = addr_q + dte_pkg::PTR_SEG_OFS;
              state_d = dte_pkg::S_RD;
            end else begin
              dseg_we = (op == dte_pkg::OP_PTRDSEG); // RQ9
              xseg_we = (op == dte_pkg::OP_PTRXSEG); // RQ10
            end
          end
          dte_pkg::OP_FLPOP: begin
            fl_we = 1'b1; // RQ14 RQ15
            stk_we = 1'b1;
            stk_data = stk_ptr + dte_pkg::STACK_STEP;
          end
          default: ;
        endcase
      end
      dte_pkg::S_WR: state_d = dte_pkg::S_IDLE;
      dte_pkg::S_WB: begin
        rf_we = 1'b1; // RQ4
        rf_sel = ssel;
        rf_data = tmp_q;
        state_d = dte_pkg::S_IDLE;
      end
      dte_pkg::S_IO: begin
        if (io_ack_in) begin
          rf_we = (op == dte_pkg::OP_IN); // RQ6
          rf_word = w;
          rf_sel = dte_pkg::SEL_ACC_LO;
          rf_data = io_rdata_in;
          state_d = dte_pkg::S_IDLE;
        end
      end
      default: state_d = dte_pkg::S_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= dte_pkg::S_IDLE;
      addr_q <= dte_pkg::REG_RESET;
      tmp_q <= dte_pkg::REG_RESET;
      phase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      tmp_q <= tmp_d;
      phase_q <= phase_d;
    end
  end

  // unknown operation code flag, cleared by the next command
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) bad_op_q <= 1'b0;
    else if (start) bad_op_q <= 1'b0;
    else if (state_q == dte_pkg::S_DEC && cmd_q[3:0] > dte_pkg::OP_FLPOP) bad_op_q <= 1'b1;
  end

  // port cycle address and data
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      io_wr_out <= 1'b0;
      io_word_out <= 1'b0;
      io_addr_out <= dte_pkg::REG_RESET;
      io_wdata_out <= dte_pkg::REG_RESET;
    end else if (state_q == dte_pkg::S_DEC && op inside {dte_pkg::OP_IN, dte_pkg::OP_OUT}) begin
      io_wr_out <= (op == dte_pkg::OP_OUT); // RQ7
      io_word_out <= w;
      io_addr_out <= cmd_q[dte_pkg::CMD_IMM] ? {8'h00, imm_q[7:0]} : gpr[dte_pkg::R_PORT];
      io_wdata_out <= w ? gpr[dte_pkg::R_ACC] : {8'h00, gpr[dte_pkg::R_ACC][7:0]}; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand and stack memory
  dte_mem u_mem (
    .mclk_in(mclk_in),
    .en_in(state_q == dte_pkg::S_RD || state_q == dte_pkg::S_WR),
    .we_in(state_q == dte_pkg::S_WR),
    .be_in(op_word ? 2'h3 : (addr_q[0] ? 2'h2 : 2'h1)),
    .addr_in(addr_q[dte_pkg::MEM_AW:1]),
    .wdata_in(op_word ? tmp_q : {tmp_q[7:0], tmp_q[7:0]}),
    .rdata_out(mem_rdata)
  );
endmodule : dte_core

// ---- verif/dte_monitor.sv ----
module dte_monitor (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic io_req_out,
  input wire logic io_wr_out,
  input wire logic io_word_out,
  input wire logic [15:0] io_addr_out,
  input wire logic [15:0] io_wdata_out,
  input wire logic io_ack_in,
  input wire logic bus_lock_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  // command sequencing and port cycles
  chk_lock_in_cmd: assert property (bus_lock_out |-> busy_out)
    else $error("bus lock outside a command");
  chk_io_in_cmd: assert property (io_req_out |-> busy_out)
    else $error("port cycle outside a command");
  chk_io_after_dec: assert property ($rose(io_req_out) |-> $past(busy_out))
    else $error("port cycle began without decode");
  chk_io_fields_hold: assert property (io_req_out && !io_ack_in |=> io_req_out &&
    $stable(io_addr_out) && $stable(io_wr_out) && $stable(io_word_out) && $stable(io_wdata_out))
    else $error("port cycle fields moved before ack");
  chk_io_release: assert property (io_req_out && io_ack_in |=> !io_req_out)
    else $error("port request held after ack");
  ////////////////////////////////////////////////////////////////////////////
  // register bus answers; zero-extended byte port output
  chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out && !s_axi_bvalid_out |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
  chk_read_once: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read response repeated");
  chk_write_once: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response repeated");
  chk_io_byte_zero: assert property (io_req_out && io_wr_out && !io_word_out
    |-> io_wdata_out[15:8] == 8'h00)
    else $error("byte output not zero-extended");
endmodule : dte_monitor

// ---- verif/tb_data_transfer_execution.sv ----
module tb_data_transfer_execution;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rst_in, aw_v, aw_rdy, w_v, w_rdy, b_v, b_r, ar_v, ar_rdy, r_v, r_r;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp, lg_kind, dly;
  logic io_req, io_wr, io_word, io_ack, lock, busy;
  logic [15:0] io_addr, io_wd, io_rd, lg_addr, lg_wd;
  logic [31:0] d;
  logic [1:0] r;
  logic [3:0] w_s;
  int fail_count, n_checks, cyc;
  // rows: kind (0 write, 1 command, 2 read check, 3 port check), address, value
  logic [25:0] rows [] = '{
    {2'h0, 8'h00, 16'h1234}, {2'h0, 8'h04, 16'h5678}, {2'h0, 8'h08, 16'hffff},
    {2'h0, 8'h0c, 16'h0100}, {2'h0, 8'h10, 16'h0000}, {2'h0, 8'h14, 16'ha5c3},
    {2'h0, 8'h28, 16'h0945}, {2'h1, 8'h00, 16'h0030},
    {2'h2, 8'h04, 16'h1234}, {2'h2, 8'h00, 16'h1234},
    {2'h1, 8'h00, 16'h0511}, {2'h2, 8'h10, 16'hfffe},
    {2'h1, 8'h00, 16'h00d2}, {2'h2, 8'h18, 16'ha5c3},
    {2'h2, 8'h10, 16'h0000},
    {2'h0, 8'h2c, 16'h0134}, {2'h1, 8'h00, 16'h1d10}, {2'h1, 8'h00, 16'h0004},
    {2'h2, 8'h00, 16'h12c3},
    {2'h1, 8'h00, 16'h0033}, {2'h2, 8'h00, 16'h1234}, {2'h2, 8'h04, 16'h12c3},
    {2'h1, 8'h00, 16'h4033}, {2'h2, 8'h00, 16'h12c3}, {2'h2, 8'h04, 16'h1234},
    {2'h1, 8'h00, 16'h08d7}, {2'h2, 8'h18, 16'h0134}, {2'h2, 8'h28, 16'h0945},
    {2'h0, 8'h2c, 16'h0136}, {2'h1, 8'h00, 16'h1910}, {2'h0, 8'h2c, 16'h0134},
    {2'h1, 8'h00, 16'h08f8}, {2'h2, 8'h1c, 16'ha5c3}, {2'h2, 8'h20, 16'h1234},
    {2'h1, 8'h00, 16'h0839}, {2'h2, 8'h04, 16'ha5c3}, {2'h2, 8'h24, 16'h1234},
    {2'h1, 8'h00, 16'h000a}, {2'h2, 8'h00, 16'h45c3}, {2'h2, 8'h28, 16'h0945},
    {2'h0, 8'h00, 16'h9aff}, {2'h1, 8'h00, 16'h000b}, {2'h2, 8'h28, 16'h0990},
    {2'h1, 8'h00, 16'h000c}, {2'h2, 8'h10, 16'hfffe},
    {2'h0, 8'h2c, 16'hfffe}, {2'h1, 8'h00, 16'h08f0}, {2'h2, 8'h1c, 16'h0990},
    {2'h0, 8'h14, 16'hf89b}, {2'h1, 8'h00, 16'h1d10}, {2'h1, 8'h00, 16'h000d},
    {2'h2, 8'h28, 16'h0891}, {2'h2, 8'h10, 16'h0000},
    {2'h0, 8'h30, 16'h00a7}, {2'h1, 8'h00, 16'h2005}, {2'h3, 8'h00, 16'h00a7},
    {2'h2, 8'h00, 16'h9aef}, {2'h1, 8'h00, 16'h0015}, {2'h3, 8'h01, 16'hffff},
    {2'h2, 8'h00, 16'hbeef}, {2'h1, 8'h00, 16'h2006}, {2'h3, 8'h02, 16'h00a7},
    {2'h3, 8'h80, 16'h00ef}, {2'h1, 8'h00, 16'h0016}, {2'h3, 8'h03, 16'hffff},
    {2'h3, 8'h80, 16'hbeef}
  };
  dte_core DUT (.mclk_in(mclk_in), .rst_in(rst_in), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_rdy), .s_axi_awaddr_in(aw_a), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s),
    .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r), .s_axi_bresp_out(b_resp),
    .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_rdy), .s_axi_araddr_in(ar_a),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .s_axi_rdata_out(r_d),
    .s_axi_rresp_out(r_resp), .io_req_out(io_req), .io_wr_out(io_wr), .io_word_out(io_word),
    .io_addr_out(io_addr), .io_wdata_out(io_wd), .io_rdata_in(io_rd), .io_ack_in(io_ack),
    .bus_lock_out(lock), .busy_out(busy));
  ////////////////////////////////////////////////////////////////////////////
  // clock, timeout and slow port responder
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ack after three waiting cycles; data bus shows junk outside the ack
  always @(posedge mclk_in) begin
    if (io_req && io_ack) begin
      lg_kind <= {io_wr, io_word};
      lg_addr <= io_addr;
      lg_wd <= io_wd;
    end
    dly <= (io_req && !io_ack) ? dly + 2'h1 : 2'h0;
    io_ack <= io_req && !io_ack && dly == 2'h2;
    io_rd <= (io_req && !io_ack && dly == 2'h2) ? 16'hbeef : ~io_rd;
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus tasks and comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge mclk_in);
    aw_v <= 1'b1; aw_a <= a; w_v <= 1'b1; w_d <= {16'h0000, v}; b_r <= 1'b1;
    while (!(da && dw)) begin
      @(negedge mclk_in);
      ta = !da && aw_rdy;
      tw = !dw && w_rdy;
      @(posedge mclk_in);
      if (ta) begin da = 1'b1; aw_v <= 1'b0; end
      if (tw) begin dw = 1'b1; w_v <= 1'b0; end
    end
    do @(negedge mclk_in); while (b_v !== 1'b1);
    rs = b_resp;
    @(posedge mclk_in);
    b_r <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk_in);
    ar_v <= 1'b1; ar_a <= a; r_r <= 1'b1;
    do @(negedge mclk_in); while (ar_rdy !== 1'b1);
    @(posedge mclk_in);
    ar_v <= 1'b0;
    do @(negedge mclk_in); while (r_v !== 1'b1);
    v = r_d;
    rs = r_resp;
    @(posedge mclk_in);
    r_r <= 1'b0;
  endtask : axi_rd
  // write the command word, then poll status until idle
  task automatic do_cmd(input logic [15:0] c);
    axi_wr(dte_pkg::OFF_CMD, c, r);
    do axi_rd(dte_pkg::OFF_STAT, d, r); while (d[0] !== 1'b0);
  endtask : do_cmd
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_in = 1'b1; aw_v = 1'b0; aw_a = 8'h00; w_v = 1'b0; w_d = '0; b_r = 1'b0;
    ar_v = 1'b0; ar_a = 8'h00; r_r = 1'b0;
    fail_count = 0; n_checks = 0; w_s = 4'hf;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      case (rows[i][25:24])
        2'h0: axi_wr(rows[i][23:16], rows[i][15:0], r);
        2'h1: do_cmd(rows[i][15:0]);
        2'h2: begin
          axi_rd(rows[i][23:16], d, r);
          chk(d, {16'h0000, rows[i][15:0]});
        end
        default: chk(rows[i][23] ? {16'h0000, lg_wd} : {14'h0000, lg_kind, lg_addr},
          {14'h0000, rows[i][17:16], rows[i][15:0]});
      endcase
    end
    $display("table done");
    // unmapped place refused on both paths
    axi_wr(8'h3c, 16'h5555, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, dte_pkg::RESP_DECERR});
    axi_rd(8'h3c, d, r);
    chk({d[29:0], r}, {30'h0000_0000, dte_pkg::RESP_DECERR});
    do_cmd(16'h000e);
    chk({31'h0000_0000, d[2]}, {31'h0000_0000, 1'b1});
    // low strobe only keeps the upper byte of a general register
    w_s <= 4'h1;
    axi_wr(8'h04, 16'hbbaa, r);
    w_s <= 4'hf;
    axi_rd(8'h04, d, r);
    chk(d, 32'h0000_a5aa);
    $display("refusal done");
    // reset in mid-run clears flags and accumulator
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    axi_rd(dte_pkg::OFF_FLAGS, d, r);
    chk(d, {16'h0000, dte_pkg::FL_RESET});
    axi_rd(8'h00, d, r);
    chk(d, {16'h0000, dte_pkg::REG_RESET});
    $display("reset done");
    results();
  end
endmodule : tb_data_transfer_execution
bind dte_core dte_monitor u_mon (.mclk_in(mclk_in), .rst_in(rst_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .io_req_out(io_req_out), .io_wr_out(io_wr_out), .io_word_out(io_word_out),
  .io_addr_out(io_addr_out), .io_wdata_out(io_wdata_out), .io_ack_in(io_ack_in),
  .bus_lock_out(bus_lock_out), .busy_out(busy_out));
